// >>> pkg/port_a_pkg.sv
// constants and types shared by the port A low-pin function select block
package port_a_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses on the 32-bit register bus)
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_FUNC_SEL = 12'h000;  // port_a_function_select
  localparam logic [11:0] OFS_STATUS   = 12'h004;  // routing and mode readback
  localparam int          ADDR_W       = 12;

  // ----------------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------------
  localparam int          LOW_PINS        = 12;     // pins 11 down to 0
  localparam int          FUNC_SEL_W      = 16;     // full register width
  localparam logic [15:0] FUNC_SEL_RESET  = 16'h0000;
  localparam int          STATUS_MODE_LSB = 16;     // mode field in status word

  // ----------------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // operating mode, fixed at boot from the mode straps
  // ----------------------------------------------------------------------
  localparam logic [1:0] STRAP_EXP_ROM_OFF = 2'h0;
  localparam logic [1:0] STRAP_EXP_ROM_ON  = 2'h1;
  localparam logic [1:0] STRAP_SINGLE      = 2'h2;

  typedef enum logic [1:0] {
    MODE_EXP_ROM_OFF,
    MODE_EXP_ROM_ON,
    MODE_SINGLE
  } mode_t;

endpackage

// >>> pkg/pin_route_if.sv
// signals between the register side and the per-pin routing logic
interface pin_route_if;
  logic [port_a_pkg::LOW_PINS-1:0] selNxt;    // function bits, value after this edge
  port_a_pkg::mode_t               modeNxt;   // operating mode after this edge
  logic [port_a_pkg::LOW_PINS-1:0] dirBits;   // direction bits for gpio use
  logic [port_a_pkg::LOW_PINS-1:0] addrLines; // external address lines
  logic [port_a_pkg::LOW_PINS-1:0] gpioData;  // gpio output data
  logic [port_a_pkg::LOW_PINS-1:0] padIn;     // pad input level
  logic [port_a_pkg::LOW_PINS-1:0] padOut;    // pad output level
  logic [port_a_pkg::LOW_PINS-1:0] padOe;     // pad output enable
  logic [port_a_pkg::LOW_PINS-1:0] gpioIn;    // sampled pad level
  logic [port_a_pkg::LOW_PINS-1:0] addrSel;   // pin currently drives address

  modport ctrl (output selNxt, output modeNxt, output dirBits, output addrLines,
                output gpioData, output padIn,
                input padOut, input padOe, input gpioIn, input addrSel);
  modport route (input selNxt, input modeNxt, input dirBits, input addrLines,
                 input gpioData, input padIn,
                 output padOut, output padOe, output gpioIn, output addrSel);
endinterface

// >>> rtl/pin_route.sv
// per-pin choice between address output and general-purpose i/o
module pin_route (
  input wire logic    clock,  // system clock
  input wire logic    rstn,   // power-on reset, active low
  pin_route_if.route  pr      // routing controls and pad signals
);

  logic [port_a_pkg::LOW_PINS-1:0] padOut_r;
  logic [port_a_pkg::LOW_PINS-1:0] padOut_nxt;
  logic [port_a_pkg::LOW_PINS-1:0] padOe_r;
  logic [port_a_pkg::LOW_PINS-1:0] padOe_nxt;
  logic [port_a_pkg::LOW_PINS-1:0] gpioIn_r;
  logic [port_a_pkg::LOW_PINS-1:0] addrSel_r;
  logic [port_a_pkg::LOW_PINS-1:0] addrSel_nxt;

  // ----------------------------------------------------------------------
  // routing, one cell per pin
  // ----------------------------------------------------------------------
  // built from the register's next value so the new routing is in place
  // on the very edge that completes the write
  genvar n;
  generate
    for (n = 0; n < port_a_pkg::LOW_PINS; n++) begin : g_pin
      always_comb begin
        unique case (pr.modeNxt)
          port_a_pkg::MODE_EXP_ROM_OFF: addrSel_nxt[n] = 1'b1;
          port_a_pkg::MODE_EXP_ROM_ON:  addrSel_nxt[n] = pr.selNxt[n];
          port_a_pkg::MODE_SINGLE:      addrSel_nxt[n] = 1'b0;
        endcase
        padOut_nxt[n] = addrSel_nxt[n] ? pr.addrLines[n] : pr.gpioData[n];
        padOe_nxt[n]  = addrSel_nxt[n] | pr.dirBits[n];
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      padOut_r  <= '0;
      padOe_r   <= '0;
      gpioIn_r  <= '0;
      addrSel_r <= '0;
    end else begin
      padOut_r  <= padOut_nxt;
      padOe_r   <= padOe_nxt;
      gpioIn_r  <= pr.padIn;
      addrSel_r <= addrSel_nxt;
    end
  end

  assign pr.padOut  = padOut_r;
  assign pr.padOe   = padOe_r;
  assign pr.gpioIn  = gpioIn_r;
  assign pr.addrSel = addrSel_r;

endmodule

// >>> rtl/port_a_low_pin_function_select.sv
// port A low-pin function select: register slave and boot mode capture

module port_a_low_pin_function_select (
  input  wire logic                                clock,        // 250 MHz system clock
  input  wire logic                                rstn,         // power-on reset, active low
  input  wire logic                                hwStandby,    // hardware standby, clears reg
  input  wire logic [1:0]                          modeStrap,    // boot mode straps
  // axi4-lite slave
  input  wire logic [port_a_pkg::ADDR_W-1:0]       s_axi_awaddr, // write address
  input  wire logic                                s_axi_awvalid,// write address valid
  output logic                                     s_axi_awready,// write address ready
  input  wire logic [31:0]                         s_axi_wdata,  // write data
  input  wire logic [3:0]                          s_axi_wstrb,  // byte strobes
  input  wire logic                                s_axi_wvalid, // write data valid
  output logic                                     s_axi_wready, // write data ready
  output logic [1:0]                               s_axi_bresp,  // write response
  output logic                                     s_axi_bvalid, // write response valid
  input  wire logic                                s_axi_bready, // write response ready
  input  wire logic [port_a_pkg::ADDR_W-1:0]       s_axi_araddr, // read address
  input  wire logic                                s_axi_arvalid,// read address valid
  output logic                                     s_axi_arready,// read address ready
  output logic [31:0]                              s_axi_rdata,  // read data
  output logic [1:0]                               s_axi_rresp,  // read response
  output logic                                     s_axi_rvalid, // read data valid
  input  wire logic                                s_axi_rready, // read data ready
  // pins and their sources
  input  wire logic [port_a_pkg::LOW_PINS-1:0]     portADirection,// direction bits, 1 = out
  input  wire logic [port_a_pkg::LOW_PINS-1:0]     extAddrLine,  // external address 11..0
  input  wire logic [port_a_pkg::LOW_PINS-1:0]     gpioLineOut,  // gpio output data 11..0
  input  wire logic [port_a_pkg::LOW_PINS-1:0]     padIn,        // pad input levels
  output logic      [port_a_pkg::LOW_PINS-1:0]     padOut,       // pad output levels
  output logic      [port_a_pkg::LOW_PINS-1:0]     padOe,        // pad output enables
  output logic      [port_a_pkg::LOW_PINS-1:0]     gpioLineIn,   // sampled gpio input
  output logic      [port_a_pkg::LOW_PINS-1:0]     addrSelected  // pin drives address
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [port_a_pkg::FUNC_SEL_W-1:0] funcSel_r;
  logic [port_a_pkg::FUNC_SEL_W-1:0] funcSel_nxt;
  port_a_pkg::mode_t                 mode_r;
  port_a_pkg::mode_t                 mode_nxt;
  logic                              modeTaken_r;
  logic                              modeTaken_nxt;

  logic                              awHeld_r;
  logic                              awHeld_nxt;
  logic [port_a_pkg::ADDR_W-1:0]     awAddr_r;
  logic [port_a_pkg::ADDR_W-1:0]     awAddr_nxt;
  logic                              wHeld_r;
  logic                              wHeld_nxt;
  logic [31:0]                       wData_r;
  logic [31:0]                       wData_nxt;
  logic [3:0]                        wStrb_r;
  logic [3:0]                        wStrb_nxt;
  logic                              bValid_r;
  logic                              bValid_nxt;
  logic [1:0]                        bResp_r;
  logic [1:0]                        bResp_nxt;
  logic                              rValid_r;
  logic                              rValid_nxt;
  logic [1:0]                        rResp_r;
  logic [1:0]                        rResp_nxt;
  logic [31:0]                       rData_r;
  logic [31:0]                       rData_nxt;
  logic                              awReady_r;
  logic                              awReady_nxt;
  logic                              wReady_r;
  logic                              wReady_nxt;
  logic                              arReady_r;
  logic                              arReady_nxt;

  logic                              doWrite;
  logic                              hitFuncSel;
  logic [31:0]                       statusWord;

  pin_route_if pr ();

  // ----------------------------------------------------------------------
  // boot mode capture
  // ----------------------------------------------------------------------
  // straps are caught on the first edge after reset release, never by
  // the asynchronous reset itself; the mode then stays fixed until reset
  always_comb begin
    mode_nxt      = mode_r;
    modeTaken_nxt = 1'b1;
    if (!modeTaken_r) begin
      unique case (modeStrap)
        port_a_pkg::STRAP_EXP_ROM_OFF: mode_nxt = port_a_pkg::MODE_EXP_ROM_OFF;
        port_a_pkg::STRAP_EXP_ROM_ON:  mode_nxt = port_a_pkg::MODE_EXP_ROM_ON;
        default:                       mode_nxt = port_a_pkg::MODE_SINGLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_r      <= port_a_pkg::MODE_SINGLE;
      modeTaken_r <= 1'b0;
    end else begin
      mode_r      <= mode_nxt;
      modeTaken_r <= modeTaken_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // write channels: address and data accepted in either order
  // ----------------------------------------------------------------------
  assign doWrite    = awHeld_r && wHeld_r && !bValid_r;
  assign hitFuncSel = (awAddr_r[port_a_pkg::ADDR_W-1:2] == port_a_pkg::OFS_FUNC_SEL[11:2]);

  always_comb begin
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt  = wHeld_r;
    wData_nxt  = wData_r;
    wStrb_nxt  = wStrb_r;
    bValid_nxt = bValid_r;
    bResp_nxt  = bResp_r;
    if (s_axi_awvalid && !awHeld_r) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt  = hitFuncSel ? port_a_pkg::RESP_OKAY : port_a_pkg::RESP_SLVERR;
    end else if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
    // ready kept in its own flop so the port has no gate in front of it
    awReady_nxt = !awHeld_nxt;
    wReady_nxt  = !wHeld_nxt;
  end

  // ----------------------------------------------------------------------
  // function select register
  // ----------------------------------------------------------------------
  // standby wins over a write in the same cycle: the port must come out
  // of standby in its reset routing
  always_comb begin
    funcSel_nxt = funcSel_r;
    if (hwStandby) begin
      funcSel_nxt = port_a_pkg::FUNC_SEL_RESET;
    end else if (doWrite && hitFuncSel) begin
      if (wStrb_r[0]) begin
        funcSel_nxt[7:0] = wData_r[7:0];
      end
      if (wStrb_r[1]) begin
        funcSel_nxt[15:8] = wData_r[15:8];
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      funcSel_r <= port_a_pkg::FUNC_SEL_RESET;
      awHeld_r  <= 1'b0;
      awAddr_r  <= '0;
      wHeld_r   <= 1'b0;
      wData_r   <= '0;
      wStrb_r   <= '0;
      bValid_r  <= 1'b0;
      bResp_r   <= port_a_pkg::RESP_OKAY;
      awReady_r <= 1'b1;
      wReady_r  <= 1'b1;
    end else begin
      funcSel_r <= funcSel_nxt;
      awHeld_r  <= awHeld_nxt;
      awAddr_r  <= awAddr_nxt;
      wHeld_r   <= wHeld_nxt;
      wData_r   <= wData_nxt;
      wStrb_r   <= wStrb_nxt;
      bValid_r  <= bValid_nxt;
      bResp_r   <= bResp_nxt;
      awReady_r <= awReady_nxt;
      wReady_r  <= wReady_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // read channel: answer one cycle after the address is taken
  // ----------------------------------------------------------------------
  always_comb begin
    statusWord = '0;
    statusWord[port_a_pkg::LOW_PINS-1:0] = pr.addrSel;
    statusWord[port_a_pkg::STATUS_MODE_LSB +: 2] = mode_r;
  end

  always_comb begin
    rValid_nxt = rValid_r;
    rResp_nxt  = rResp_r;
    rData_nxt  = rData_r;
    if (!rValid_r && s_axi_arvalid) begin
      rValid_nxt = 1'b1;
      rResp_nxt  = port_a_pkg::RESP_OKAY;
      if (s_axi_araddr[port_a_pkg::ADDR_W-1:2] == port_a_pkg::OFS_FUNC_SEL[11:2]) begin
        rData_nxt = {16'h0000, funcSel_r};
      end else if (s_axi_araddr[port_a_pkg::ADDR_W-1:2] == port_a_pkg::OFS_STATUS[11:2]) begin
        rData_nxt = statusWord;
      end else begin
        rData_nxt = 32'h0000_0000;
        rResp_nxt = port_a_pkg::RESP_SLVERR;
      end
    end else if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
    end
    arReady_nxt = !rValid_nxt;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rValid_r <= 1'b0;
      rResp_r  <= port_a_pkg::RESP_OKAY;
      rData_r  <= '0;
      arReady_r <= 1'b1;
    end else begin
      rValid_r <= rValid_nxt;
      rResp_r  <= rResp_nxt;
      rData_r  <= rData_nxt;
      arReady_r <= arReady_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------------
  assign pr.selNxt    = funcSel_nxt[port_a_pkg::LOW_PINS-1:0];
  assign pr.modeNxt   = mode_nxt;
  assign pr.dirBits   = portADirection;
  assign pr.addrLines = extAddrLine;
  assign pr.gpioData  = gpioLineOut;
  assign pr.padIn     = padIn;

  pin_route u_route (
    .clock (clock),
    .rstn  (rstn),
    .pr    (pr.route)
  );

  // ----------------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------------
  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rresp   = rResp_r;
  assign s_axi_rdata   = rData_r;
  assign padOut        = pr.padOut;
  assign padOe         = pr.padOe;
  assign gpioLineIn    = pr.gpioIn;
  assign addrSelected  = pr.addrSel;

endmodule

// >>> verif/pa_fsel_sva.sv
// port-level assertions for the port A low-pin function select block
module pa_fsel_sva (
  input wire logic        clock,          // system clock
  input wire logic        rstn,           // power-on reset, active low
  input wire logic        hwStandby,      // hardware standby
  input wire logic [1:0]  modeStrap,      // boot mode straps
  input wire logic        s_axi_arvalid,  // read address valid
  input wire logic        s_axi_arready,  // read address ready
  input wire logic        s_axi_rvalid,   // read data valid
  input wire logic        s_axi_bvalid,   // write response valid
  input wire logic [11:0] portADirection, // direction bits
  input wire logic [11:0] extAddrLine,    // address lines
  input wire logic [11:0] gpioLineOut,    // gpio output data
  input wire logic [11:0] padIn,          // pad levels
  input wire logic [11:0] padOut,         // pad output levels
  input wire logic [11:0] padOe,          // pad output enables
  input wire logic [11:0] gpioLineIn,     // sampled pad levels
  input wire logic [11:0] addrSelected    // pin drives address
);
  logic       up_r;
  logic [1:0] strap_r;
  // own copy of the boot mode, taken at the same edge as the block's
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      up_r    <= 1'b0;
      strap_r <= 2'h0;
    end else begin
      up_r <= 1'b1;
      if (!up_r) strap_r <= modeStrap;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  reset_idle_a: assert property (
    !up_r |-> padOe == 12'h000 && addrSelected == 12'h000 && !s_axi_bvalid)
    else $error("pins not idle after reset");
  rom_off_a: assert property (
    up_r && strap_r == 2'h0 |-> addrSelected == 12'hfff) else $error("rom-off pin not address");
  single_gpio_a: assert property (
    up_r && strap_r[1] |-> addrSelected == 12'h000) else $error("single-chip pin not gpio");
  pad_enable_a: assert property (
    up_r |-> padOe == (addrSelected | $past(portADirection))) else $error("pad enable wrong");
  pad_level_a: assert property (
    up_r |-> padOut == ((addrSelected & $past(extAddrLine)) |
                        (~addrSelected & $past(gpioLineOut))))
    else $error("pad level wrong");
  gpio_sample_a: assert property (
    up_r |-> gpioLineIn == $past(padIn)) else $error("gpio input not sampled");
  route_hold_a: assert property (
    up_r && $past(up_r) && $changed(addrSelected) |-> $rose(s_axi_bvalid) || $past(hwStandby))
    else $error("routing moved without a write");
  standby_clear_a: assert property (
    up_r && strap_r == 2'h1 && hwStandby |=> addrSelected == 12'h000)
    else $error("standby left routing");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
endmodule
bind port_a_low_pin_function_select pa_fsel_sva chk (.*);

// >>> verif/pa_board_model.sv
// board side of the shared pins: weak drive, the device's drive wins
module pa_board_model (
  input wire logic [11:0] padOut,     // device drive level
  input wire logic [11:0] padOe,      // device drive enable
  input wire logic [11:0] boardLevel, // level the board holds
  output logic     [11:0] padIn       // resolved pad level
);
  // resistive board drive, so an enabled device pin always overrides it
  assign padIn = (padOe & padOut) | (~padOe & boardLevel);
endmodule

// >>> verif/testbench.sv
// self-checking bench for the port A low-pin function select block
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin nErrors++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        hwStandby = 1'b0;
  logic [1:0]  modeStrap = 2'h0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_rdata;
  logic [11:0] portADirection = 12'h0f0, extAddrLine = 12'h9c6;
  logic [11:0] gpioLineOut = 12'h555, boardLevel = 12'h3a5;
  logic [11:0] padIn, padOut, padOe, gpioLineIn, addrSelected;
  int          nErrors = 0;
  int          checkCount = 0;
  port_a_low_pin_function_select dut (.*);
  pa_board_model board (.*);
  initial forever #2 clock = ~clock;
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic writeChk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
    // a write that is never answered counts as a mismatch
    `CHK(s_axi_bvalid, 1'b1)
    `CHK(s_axi_bresp, er)
    s_axi_bready <= 1'b0;
  endtask
  task automatic readChk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
    `CHK(s_axi_rvalid, 1'b1)
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [11:0] expSel(input logic [1:0] m, input logic [11:0] f);
    case (m)
      2'h0: return 12'hfff;
      2'h1: return f;
      default: return 12'h000;
    endcase
  endfunction
  initial begin
    logic [11:0] sel;
    logic [11:0] oe;
    logic [11:0] po;
    for (int m = 0; m < 4; m++) begin
      rstn      <= 1'b0;
      modeStrap <= m[1:0];
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (2) @(posedge clock);
      sel = expSel(m[1:0], 12'h000);
      readChk(port_a_pkg::OFS_FUNC_SEL, 32'h0000_0000, port_a_pkg::RESP_OKAY);
      readChk(port_a_pkg::OFS_STATUS, {14'h0000, (m[1] ? 2'h2 : m[1:0]), 4'h0, sel},
              port_a_pkg::RESP_OKAY);
      writeChk(port_a_pkg::OFS_FUNC_SEL, 32'h0000_5a3c, 4'h3, port_a_pkg::RESP_OKAY);
      sel = expSel(m[1:0], 12'ha3c);
      `CHK(addrSelected, sel)
      readChk(port_a_pkg::OFS_FUNC_SEL, 32'h0000_5a3c, port_a_pkg::RESP_OKAY);
      repeat (2) @(posedge clock);
      oe = sel | portADirection;
      po = (sel & extAddrLine) | (~sel & gpioLineOut);
      `CHK(padOe, oe)
      `CHK(padOut, po)
      `CHK(gpioLineIn, (oe & po) | (~oe & boardLevel))
      // only the low byte lane may land
      writeChk(port_a_pkg::OFS_FUNC_SEL, 32'hffff_00ff, 4'h1, port_a_pkg::RESP_OKAY);
      readChk(port_a_pkg::OFS_FUNC_SEL, 32'h0000_5aff, port_a_pkg::RESP_OKAY);
      `CHK(addrSelected, expSel(m[1:0], 12'haff))
      writeChk(port_a_pkg::OFS_STATUS, 32'h0000_0000, 4'hf, port_a_pkg::RESP_SLVERR);
      readChk(12'h008, 32'h0000_0000, port_a_pkg::RESP_SLVERR);
      @(posedge clock);
      hwStandby <= 1'b1;
      @(posedge clock);
      hwStandby <= 1'b0;
      readChk(port_a_pkg::OFS_FUNC_SEL, 32'h0000_0000, port_a_pkg::RESP_OKAY);
      `CHK(addrSelected, expSel(m[1:0], 12'h000))
      $display("mode strap %0d test done", m);
      extAddrLine    <= ~extAddrLine;
      gpioLineOut    <= ~gpioLineOut;
      portADirection <= ~portADirection;
      boardLevel     <= ~boardLevel;
    end
    summarize();
  end
  // whole run is about 0.6 us; this leaves a wide margin
  initial begin
    #20000;
    nErrors++;
    summarize();
  end
endmodule
